// file: core/bcb_pkg.sv
// constants and types shared by the external area controller
package bcb_pkg;

  // ==========================================================
  // register offsets (byte addresses on the register bus)
  localparam logic [7:0] OFS_CMN  = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  // index 0 = area 0, 1 = card area 5, 2 = card area 6
  localparam logic [7:0] OFS_BCR [0:2] = '{8'h04, 8'h0C, 8'h14};
  localparam logic [7:0] OFS_WCR [0:2] = '{8'h08, 8'h10, 8'h18};

  // ==========================================================
  // field positions
  localparam int CMN_MAP_BIT = 0;
  localparam int CMN_BIG_BIT = 1;
  localparam int BCR_BWD_LSB = 0;
  localparam int BCR_TYP_LSB = 2;
  localparam int WCR_W_LSB   = 0;
  localparam int WCR_BWT_LSB = 4;
  localparam int WCR_HWT_LSB = 6;
  localparam int WCR_BST_BIT = 8;
  localparam int WCR_EDL_LSB = 9;
  localparam int WCR_EHL_LSB = 13;
  localparam int WCR_SPA_LSB = 17;

  // ==========================================================
  // reset values
  localparam logic [31:0] CMN_RST = 32'h0000_0000;
  localparam logic [31:0] BCR_RST = 32'h0000_0003;
  localparam logic [31:0] WCR_RST = 32'h0002_0000;

  // ==========================================================
  // encodings
  localparam logic [3:0] TYP_NORMAL  = 4'h0;
  localparam logic [3:0] TYP_BYTESEL = 4'h1;
  localparam logic [3:0] TYP_CARD    = 4'h5;
  localparam logic [3:0] TYP_SBURST  = 4'h7;
  localparam logic [1:0] BWD_8       = 2'h1;
  localparam logic [1:0] BWD_16      = 2'h2;
  localparam logic [1:0] BWD_32      = 2'h3;
  localparam logic [1:0] SZ_BYTE     = 2'h0;
  localparam logic [1:0] SZ_WORD     = 2'h1;
  localparam logic [1:0] SZ_LONG     = 2'h2;
  localparam logic [3:0] BLEN_16     = 4'h8;
  localparam logic [3:0] BLEN_32     = 4'h4;
  localparam logic [2:0] REG_AREA0   = 3'h0;
  localparam logic [2:0] REG_AREA5   = 3'h5;
  localparam logic [2:0] REG_AREA6   = 3'h6;

  typedef enum logic [2:0] {
    K_NONE, K_NORMAL, K_BYTESEL, K_CMEM, K_CIO, K_SBURST
  } bcb_kind_t;

endpackage

// file: core/bcb_dec_if.sv
// address decode signals between the cycle engine and the decoder
`timescale 1ns/10ps
interface bcb_dec_if;
  logic [28:0]       addr;
  logic              is_write;
  logic              map_alt;
  logic [3:0]        typ [0:2];
  logic [1:0]        sa5;
  logic [1:0]        sa6;
  bcb_pkg::bcb_kind_t kind;
  logic [1:0]        area;
  modport decoder (input addr, is_write, map_alt, typ, sa5, sa6, output kind, area);
  modport user (output addr, is_write, map_alt, typ, sa5, sa6, input kind, area);
endinterface

// file: core/bcb_area_decode.sv
// physical address to area and cycle kind
`timescale 1ns/10ps
module bcb_area_decode (
  bcb_dec_if.decoder d
);
  logic [2:0] region;
  logic       half;
  logic [1:0] spa;

  always_comb begin
    region = d.addr[28:26];
    half   = d.addr[25];
    spa    = (region == bcb_pkg::REG_AREA5) ? d.sa5 : d.sa6;
    d.area = 2'h0;
    d.kind = bcb_pkg::K_NONE;
    if (region == bcb_pkg::REG_AREA0) begin
      // burst type lives only in area 0; writes run as normal space
      if (d.typ[0] == bcb_pkg::TYP_SBURST) begin
        d.kind = d.is_write ? bcb_pkg::K_NORMAL : bcb_pkg::K_SBURST;
      end else if (d.typ[0] == bcb_pkg::TYP_BYTESEL) begin
        d.kind = bcb_pkg::K_BYTESEL;
      end else begin
        d.kind = bcb_pkg::K_NORMAL;
      end
    end else if (region == bcb_pkg::REG_AREA5 || region == bcb_pkg::REG_AREA6) begin
      d.area = (region == bcb_pkg::REG_AREA5) ? 2'h1 : 2'h2;
      if (d.map_alt && d.typ[d.area] == bcb_pkg::TYP_CARD) begin
        // spa bit set: memory card half, clear: io card half
        d.kind = spa[half] ? bcb_pkg::K_CMEM : bcb_pkg::K_CIO;
      end else begin
        d.kind = bcb_pkg::K_NORMAL;
      end
    end
  end
endmodule

// file: core/bcb_bus_ctrl.sv
// byte-select sram, card and synchronous burst rom cycle engine
// What this block does
// - timing bit clear: writes like normal space, reads drive byte selects on strobes
// - timing bit set: byte selects span the cycle, read/write strobe times the write
// - card cycles on areas 5 and 6 only with alternate map and card type
// - two-bit field maps upper and lower half to memory or io card
// - common memory of card areas runs memory card cycles only in halves whose field bit is set
// - areas 5 and 6 use own setup and hold from own wait register in card cycles only
// - card cycles take software waits and external hardware wait
// - upper io halves of areas 5 and 6 give io card cycles
// - little endian, width sense high, word io to 16-bit area 6: two bytes
// - width sense sampled in io states when enable delay nonzero, turns upper enable off
// - synchronous burst rom only on area 0, else normal-space behaviour
// - first-access wait before first beat, burst wait before later beats
// - bus start and external wait only in first burst access
// - every burst rom read runs full burst, writes run normal timing
`timescale 1ns/10ps
module bcb_bus_ctrl (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire logic [28:0] req_addr,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_size,
  input  wire logic [31:0] req_wdata,
  output logic             req_done,
  output logic             req_err,
  output logic      [31:0] req_rdata,
  output logic      [25:0] ext_addr,
  output logic             area0_sel_n,
  output logic             area5_sel_n,
  output logic             area6_sel_n,
  output logic             bus_start_n,
  output logic             rd_n,
  output logic             rd_wr_n,
  output logic      [3:0]  byte_lane_strobe_n,
  output logic             card_enable_n,
  output logic             upper_card_enable_n,
  output logic             io_rd_n,
  output logic             io_wr_n,
  output logic      [31:0] data_out,
  output logic             data_oe,
  input  wire logic [31:0] data_in,
  input  wire logic        wait_n,
  input  wire logic        io_width_sense
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACC, ST_HOLD, ST_DONE} bcb_state_t;

  // ==========================================================
  // pin synchronisers
  logic        wait_s1, wait_s2, iow_s1, iow_s2;
  logic [31:0] din_s1, din_s2;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
      iow_s1  <= 1'b0;
      iow_s2  <= 1'b0;
      din_s1  <= 32'h0000_0000;
      din_s2  <= 32'h0000_0000;
    end else if (ce) begin
      wait_s1 <= wait_n;
      wait_s2 <= wait_s1;
      iow_s1  <= io_width_sense;
      iow_s2  <= iow_s1;
      din_s1  <= data_in;
      din_s2  <= din_s1;
    end
  end

  // ==========================================================
  // register file
  logic [31:0] cmn_reg, cmn_next;
  logic [31:0] bcr_reg [0:2];
  logic [31:0] bcr_next [0:2];
  logic [31:0] wcr_reg [0:2];
  logic [31:0] wcr_next [0:2];
  logic [31:0] prdata_next, rd_val;
  logic        pready_next, pslverr_next, apb_hit, wr_go;
  logic [7:0]  status;

  assign wr_go = psel & penable & pready & pwrite;

  for (genvar i = 0; i < 3; i++) begin : g_area
    assign bcr_next[i] = (wr_go && paddr == bcb_pkg::OFS_BCR[i]) ? pwdata : bcr_reg[i];
    assign wcr_next[i] = (wr_go && paddr == bcb_pkg::OFS_WCR[i]) ? pwdata : wcr_reg[i];
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        bcr_reg[i] <= bcb_pkg::BCR_RST;
        wcr_reg[i] <= bcb_pkg::WCR_RST;
      end else if (ce) begin
        bcr_reg[i] <= bcr_next[i];
        wcr_reg[i] <= wcr_next[i];
      end
    end
  end

  always_comb begin
    apb_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    if (paddr == bcb_pkg::OFS_CMN) begin
      rd_val = cmn_reg;
    end else if (paddr == bcb_pkg::OFS_STAT) begin
      rd_val = {24'h00_0000, status};
    end else if (paddr == bcb_pkg::OFS_BCR[0]) begin
      rd_val = bcr_reg[0];
    end else if (paddr == bcb_pkg::OFS_WCR[0]) begin
      rd_val = wcr_reg[0];
    end else if (paddr == bcb_pkg::OFS_BCR[1]) begin
      rd_val = bcr_reg[1];
    end else if (paddr == bcb_pkg::OFS_WCR[1]) begin
      rd_val = wcr_reg[1];
    end else if (paddr == bcb_pkg::OFS_BCR[2]) begin
      rd_val = bcr_reg[2];
    end else if (paddr == bcb_pkg::OFS_WCR[2]) begin
      rd_val = wcr_reg[2];
    end else begin
      apb_hit = 1'b0;
    end
    cmn_next = (wr_go && paddr == bcb_pkg::OFS_CMN) ? pwdata : cmn_reg;
    // one wait state so that read data comes from a flop
    pready_next  = psel & penable & ~pready;
    prdata_next  = pready_next ? rd_val : 32'h0000_0000;
    pslverr_next = pready_next & ~apb_hit;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmn_reg <= bcb_pkg::CMN_RST;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      cmn_reg <= cmn_next;
      pready  <= pready_next;
      prdata  <= prdata_next;
      pslverr <= pslverr_next;
    end
  end

  // ==========================================================
  // address decode
  bcb_dec_if dec ();
  bcb_area_decode u_dec (.d(dec.decoder));

  assign dec.addr     = req_addr;
  assign dec.is_write = req_write;
  assign dec.map_alt  = cmn_reg[bcb_pkg::CMN_MAP_BIT];
  assign dec.typ[0]   = bcr_reg[0][bcb_pkg::BCR_TYP_LSB +: 4];
  assign dec.typ[1]   = bcr_reg[1][bcb_pkg::BCR_TYP_LSB +: 4];
  assign dec.typ[2]   = bcr_reg[2][bcb_pkg::BCR_TYP_LSB +: 4];
  assign dec.sa5      = wcr_reg[1][bcb_pkg::WCR_SPA_LSB +: 2];
  assign dec.sa6      = wcr_reg[2][bcb_pkg::WCR_SPA_LSB +: 2];

  // ==========================================================
  // cycle engine
  bcb_state_t         st_reg, st_next;
  bcb_pkg::bcb_kind_t kind_reg, kind_next;
  logic [1:0]  area_reg, area_next, size_reg, size_next;
  logic [28:0] addr_reg, addr_next;
  logic        wr_reg, wr_next, bmode_reg, bmode_next;
  logic [31:0] wdata_reg, wdata_next, rdata_next;
  logic [3:0]  cnt_reg, cnt_next, beat_reg, beat_next;
  logic [3:0]  beats_reg, beats_next, beat_inc;
  logic        done_next, err_next, card, last;
  logic [31:0] wcr_cur;
  logic [1:0]  bwd_cur, bwd_eff, bwd_new;
  logic [3:0]  f_w, f_edl, f_ehl;
  logic [1:0]  f_bwt, f_hwt;
  logic        f_bst, big;

  always_comb begin
    wcr_cur = wcr_reg[area_reg];
    bwd_cur = bcr_reg[area_reg][bcb_pkg::BCR_BWD_LSB +: 2];
    f_w     = wcr_cur[bcb_pkg::WCR_W_LSB +: 4];
    f_bwt   = wcr_cur[bcb_pkg::WCR_BWT_LSB +: 2];
    f_hwt   = wcr_cur[bcb_pkg::WCR_HWT_LSB +: 2];
    f_bst   = wcr_cur[bcb_pkg::WCR_BST_BIT];
    f_edl   = wcr_cur[bcb_pkg::WCR_EDL_LSB +: 4];
    f_ehl   = wcr_cur[bcb_pkg::WCR_EHL_LSB +: 4];
    big     = cmn_reg[bcb_pkg::CMN_BIG_BIT];
    card    = (kind_reg == bcb_pkg::K_CMEM) || (kind_reg == bcb_pkg::K_CIO);
    bwd_eff = bmode_reg ? bcb_pkg::BWD_8 : bwd_cur;
    bwd_new = bcr_reg[dec.area][bcb_pkg::BCR_BWD_LSB +: 2];
    beat_inc = 4'(beat_reg + 4'h1);
    last     = (beat_inc >= beats_reg);
    st_next    = st_reg;
    kind_next  = kind_reg;
    area_next  = area_reg;
    size_next  = size_reg;
    addr_next  = addr_reg;
    wr_next    = wr_reg;
    wdata_next = wdata_reg;
    rdata_next = req_rdata;
    cnt_next   = cnt_reg;
    beat_next  = beat_reg;
    beats_next = beats_reg;
    bmode_next = bmode_reg;
    done_next  = 1'b0;
    err_next   = req_err;
    case (st_reg)
      ST_IDLE: begin
        if (req_valid) begin
          kind_next  = dec.kind;
          area_next  = dec.area;
          addr_next  = req_addr;
          wr_next    = req_write;
          size_next  = req_size;
          wdata_next = req_wdata;
          rdata_next = 32'h0000_0000;
          beat_next  = 4'h0;
          bmode_next = 1'b0;
          err_next   = (dec.kind == bcb_pkg::K_NONE);
          cnt_next   = 4'h0;
          if (dec.kind == bcb_pkg::K_NONE) begin
            st_next = ST_DONE;
          end else begin
            st_next = ST_SETUP;
            if (dec.kind == bcb_pkg::K_CMEM || dec.kind == bcb_pkg::K_CIO) begin
              cnt_next = wcr_reg[dec.area][bcb_pkg::WCR_EDL_LSB +: 4];
            end
          end
          if (dec.kind == bcb_pkg::K_SBURST) begin
            // whole burst even for one word, extra beats dropped
            beats_next = (bwd_new == bcb_pkg::BWD_32) ? bcb_pkg::BLEN_32
                                                      : bcb_pkg::BLEN_16;
          end else if (bwd_new == bcb_pkg::BWD_8) begin
            beats_next = (req_size == bcb_pkg::SZ_LONG) ? 4'h4
                       : (req_size == bcb_pkg::SZ_WORD) ? 4'h2 : 4'h1;
          end else if (bwd_new == bcb_pkg::BWD_16 && req_size == bcb_pkg::SZ_LONG) begin
            beats_next = 4'h2;
          end else begin
            beats_next = 4'h1;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = 4'(cnt_reg - 4'h1);
        end else begin
          st_next  = ST_ACC;
          cnt_next = f_w;
        end
      end
      ST_ACC: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = 4'(cnt_reg - 4'h1);
        end else if (!wait_s2 && (kind_reg != bcb_pkg::K_SBURST || beat_reg == 4'h0)) begin
          st_next = ST_ACC;
        end else begin
          if (!wr_reg && beat_reg < 4'h4) begin
            if (bwd_eff == bcb_pkg::BWD_8) begin
              rdata_next[{beat_reg[1:0], 3'b000} +: 8] = din_s2[7:0];
            end else if (bwd_eff == bcb_pkg::BWD_16 && beat_reg < 4'h2) begin
              rdata_next[{beat_reg[0], 4'h0} +: 16] = din_s2[15:0];
            end else if (beat_reg == 4'h0) begin
              rdata_next = din_s2;
            end
          end
          if (kind_reg == bcb_pkg::K_SBURST && !last) begin
            beat_next = beat_inc;
            cnt_next  = {2'b00, f_bwt};
          end else begin
            st_next  = ST_HOLD;
            cnt_next = card ? f_ehl :
                       (kind_reg == bcb_pkg::K_BYTESEL && f_bst) ? {2'b00, f_hwt} : 4'h0;
          end
        end
        // io states: width sense narrows a word cycle to two bytes
        if (kind_reg == bcb_pkg::K_CIO && area_reg == 2'h2 && f_edl != 4'h0 &&
            !big && size_reg == bcb_pkg::SZ_WORD && bwd_cur == bcb_pkg::BWD_16 &&
            beat_reg == 4'h0 && iow_s2) begin
          bmode_next = 1'b1;
          beats_next = 4'h2;
        end
      end
      ST_HOLD: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = 4'(cnt_reg - 4'h1);
        end else if (!last) begin
          beat_next = beat_inc;
          st_next   = ST_SETUP;
          cnt_next  = card ? f_edl : 4'h0;
        end else begin
          st_next = ST_DONE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    done_next = (st_next == ST_DONE);
  end

  // ==========================================================
  // pin values, computed from the next state so pins match it
  logic        act, acc, stb_on, bst_set;
  logic [3:0]  lanes;
  logic [1:0]  bwd_pin;
  logic [4:0]  sh_bits;
  logic [25:0] ext_addr_next, beat_ofs;
  logic        a0_n_next, a5_n_next, a6_n_next, bgn_n_next, rd_n_next, rw_n_next;
  logic        ce1_n_next, ceu_n_next, iord_n_next, iowr_n_next, doe_next;
  logic [3:0]  bls_n_next;
  logic [31:0] dout_next;

  always_comb begin
    act     = (st_next == ST_SETUP) || (st_next == ST_ACC) || (st_next == ST_HOLD);
    acc     = (st_next == ST_ACC);
    bst_set = wcr_reg[area_next][bcb_pkg::WCR_BST_BIT];
    bwd_pin = bmode_next ? bcb_pkg::BWD_8 : bcr_reg[area_next][bcb_pkg::BCR_BWD_LSB +: 2];
    sh_bits = 5'h00;
    beat_ofs = 26'(beat_next);
    lanes   = 4'b1111;
    if (bwd_pin == bcb_pkg::BWD_8) begin
      lanes   = 4'b0001;
      sh_bits = {beat_next[1:0], 3'b000};
    end else if (bwd_pin == bcb_pkg::BWD_16) begin
      lanes    = (size_next == bcb_pkg::SZ_BYTE) ? (addr_next[0] ? 4'b0010 : 4'b0001)
                                                 : 4'b0011;
      sh_bits  = {beat_next[0], 4'h0};
      beat_ofs = 26'(beat_ofs << 1);
    end else begin
      if (size_next == bcb_pkg::SZ_BYTE) begin
        lanes = 4'(4'b0001 << addr_next[1:0]);
      end else if (size_next == bcb_pkg::SZ_WORD) begin
        lanes = addr_next[1] ? 4'b1100 : 4'b0011;
      end
      beat_ofs = 26'(beat_ofs << 2);
    end
    ext_addr_next = 26'(addr_next[25:0] + beat_ofs);
    a0_n_next = !(act && area_next == 2'h0);
    a5_n_next = !(act && area_next == 2'h1);
    a6_n_next = !(act && area_next == 2'h2);
    // a burst raises bus start only on its first beat
    bgn_n_next = !(acc && beat_next == 4'h0);
    rd_n_next = !(acc && !wr_next && kind_next != bcb_pkg::K_CIO);
    iord_n_next = !(acc && !wr_next && kind_next == bcb_pkg::K_CIO);
    iowr_n_next = !(acc && wr_next && kind_next == bcb_pkg::K_CIO);
    ce1_n_next  = !(act && (kind_next == bcb_pkg::K_CMEM || kind_next == bcb_pkg::K_CIO));
    ceu_n_next  = ce1_n_next || (bwd_pin != bcb_pkg::BWD_16);
    if (kind_next == bcb_pkg::K_BYTESEL && bst_set) begin
      // strobe pin then times the write, byte selects span the cycle
      rw_n_next = !(acc && wr_next);
      stb_on    = act;
    end else if (kind_next == bcb_pkg::K_BYTESEL) begin
      rw_n_next = !(act && wr_next);
      stb_on    = acc;
    end else begin
      rw_n_next = !(act && wr_next);
      stb_on    = acc && wr_next && kind_next != bcb_pkg::K_CIO;
    end
    bls_n_next = stb_on ? ~lanes : 4'b1111;
    doe_next   = act && wr_next;
    dout_next  = doe_next ? (wdata_next >> sh_bits) : 32'h0000_0000;
  end

  assign status = {bmode_reg, kind_reg, area_reg, 1'b0, st_reg != ST_IDLE};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg              <= ST_IDLE;
      kind_reg            <= bcb_pkg::K_NONE;
      area_reg            <= 2'h0;
      size_reg            <= 2'h0;
      addr_reg            <= 29'h0000_0000;
      wr_reg              <= 1'b0;
      wdata_reg           <= 32'h0000_0000;
      cnt_reg             <= 4'h0;
      beat_reg            <= 4'h0;
      beats_reg           <= 4'h1;
      bmode_reg           <= 1'b0;
      req_done            <= 1'b0;
      req_err             <= 1'b0;
      req_rdata           <= 32'h0000_0000;
      ext_addr            <= 26'h000_0000;
      area0_sel_n         <= 1'b1;
      area5_sel_n         <= 1'b1;
      area6_sel_n         <= 1'b1;
      bus_start_n         <= 1'b1;
      rd_n                <= 1'b1;
      rd_wr_n             <= 1'b1;
      byte_lane_strobe_n  <= 4'hF;
      card_enable_n       <= 1'b1;
      upper_card_enable_n <= 1'b1;
      io_rd_n             <= 1'b1;
      io_wr_n             <= 1'b1;
      data_out            <= 32'h0000_0000;
      data_oe             <= 1'b0;
    end else if (ce) begin
      st_reg              <= st_next;
      kind_reg            <= kind_next;
      area_reg            <= area_next;
      size_reg            <= size_next;
      addr_reg            <= addr_next;
      wr_reg              <= wr_next;
      wdata_reg           <= wdata_next;
      cnt_reg             <= cnt_next;
      beat_reg            <= beat_next;
      beats_reg           <= beats_next;
      bmode_reg           <= bmode_next;
      req_done            <= done_next;
      req_err             <= err_next;
      req_rdata           <= rdata_next;
      ext_addr            <= ext_addr_next;
      area0_sel_n         <= a0_n_next;
      area5_sel_n         <= a5_n_next;
      area6_sel_n         <= a6_n_next;
      bus_start_n         <= bgn_n_next;
      rd_n                <= rd_n_next;
      rd_wr_n             <= rw_n_next;
      byte_lane_strobe_n  <= bls_n_next;
      card_enable_n       <= ce1_n_next;
      upper_card_enable_n <= ceu_n_next;
      io_rd_n             <= iord_n_next;
      io_wr_n             <= iowr_n_next;
      data_out            <= dout_next;
      data_oe             <= doe_next;
    end
  end

endmodule

// file: sim/bcb_assertions.sv
// port assertions for the external area controller
`timescale 1ns/10ps
module bcb_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic area0_sel_n,
  input wire logic area5_sel_n,
  input wire logic area6_sel_n,
  input wire logic bus_start_n,
  input wire logic rd_n,
  input wire logic rd_wr_n,
  input wire logic data_oe,
  input wire logic card_enable_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n
);
  // ==========
  // strobe relations
  wire idle = area0_sel_n & area5_sel_n & area6_sel_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  card_area_a: assert property (!card_enable_n |-> !(area5_sel_n & area6_sel_n))
    else $error("card enable off area");
  io_card_a: assert property (!(io_rd_n & io_wr_n) |-> !card_enable_n & rd_n)
    else $error("io strobe bad");
  start_sel_a: assert property (!bus_start_n |-> !idle)
    else $error("start with no area");
  start_once_a: assert property ($rose(bus_start_n) |-> bus_start_n [*3])
    else $error("start repeated");
  setup_first_a: assert property ($fell(rd_n) |-> !$past(idle))
    else $error("no setup");
  card_hold_a: assert property ($rose(io_rd_n) |-> !card_enable_n)
    else $error("no card hold");
  write_drive_a: assert property (!rd_wr_n |-> data_oe)
    else $error("write undriven");
  read_quiet_a: assert property (!rd_n |-> rd_wr_n & !data_oe)
    else $error("read drives");
endmodule
bind bcb_bus_ctrl bcb_assertions u_bcb_assertions (.mclk, .rstn, .area0_sel_n, .area5_sel_n,
  .area6_sel_n, .bus_start_n, .rd_n, .rd_wr_n, .data_oe, .card_enable_n, .io_rd_n, .io_wr_n);

// file: sim/bcb_mem_model.sv
// external memory model: address pattern data, optional wait
`timescale 1ns/10ps
module bcb_mem_model (
  input  wire logic        mclk,
  input  wire logic        sel_n,
  input  wire logic        slow,
  input  wire logic [25:0] ext_addr,
  output logic      [31:0] data_in,
  output logic             wait_n,
  output logic             io_width_sense
);
  // ==========
  // deselected bus toggles so stale data never reads back
  int held = 0;
  initial data_in = 32'h5A5AA5A5;
  initial wait_n = 1'h1;
  assign io_width_sense = 1'h0;
  always @(posedge mclk) begin
    data_in <= sel_n ? ~data_in : {~ext_addr[15:0], ext_addr[15:0]};
    held <= sel_n ? 0 : held + 1;
    // fixed low window outlasts any access count, so the stretch is certain
    wait_n <= !(slow && !sel_n && held < 40);
  end
endmodule

// file: sim/byte_sram_card_burst_rom_tb_top.sv
// self-checking bench for the external area controller
`timescale 1ns/10ps
module byte_sram_card_burst_rom_tb_top;
  logic        mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        req_valid = 1'h0, req_write = 1'h0, clr = 1'h0, slow = 1'h0, err;
  logic        pready, pslverr, req_done, req_err, area0_sel_n, area5_sel_n, area6_sel_n;
  logic        bus_start_n, rd_n, rd_wr_n, wait_n, card_enable_n, io_rd_n, io_wr_n;
  logic        data_oe, io_width_sense;
  logic [7:0]  paddr = 8'h0;
  logic [1:0]  req_size = 2'h0;
  logic [25:0] ext_addr;
  logic [28:0] req_addr = 29'h0;
  logic [31:0] pwdata = 32'h0, req_wdata = 32'h0, prdata, req_rdata, data_out, data_in, rd;
  int          miscompares = 0, checks = 0, n_sel, n_rw, n_st, n_io, n_rd, w, bwt, edl, ehl;
  wire         sel_n = area0_sel_n & area5_sel_n & area6_sel_n;
  always #4 mclk = ~mclk;
  bcb_bus_ctrl u_bcb_bus_ctrl (.mclk, .rstn, .ce(1'h1), .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_addr, .req_write, .req_size,
    .req_wdata, .req_done, .req_err, .req_rdata, .ext_addr, .area0_sel_n, .area5_sel_n,
    .area6_sel_n, .bus_start_n, .rd_n, .rd_wr_n, .byte_lane_strobe_n(), .card_enable_n,
    .upper_card_enable_n(), .io_rd_n, .io_wr_n, .data_out, .data_oe, .data_in, .wait_n,
    .io_width_sense);
  bcb_mem_model u_bcb_mem_model (.mclk, .sel_n, .slow, .ext_addr, .data_in, .wait_n,
    .io_width_sense);
  // ==========
  // cycle counters, cleared as each request starts
  always @(posedge mclk)
    if (clr) {n_sel, n_rw, n_st, n_io, n_rd} <= '0;
    else begin
      n_sel <= n_sel + int'(!sel_n);
      n_rw <= n_rw + int'(!rd_wr_n);
      n_st <= n_st + int'(!bus_start_n);
      n_io <= n_io + int'(!io_rd_n);
      n_rd <= n_rd + int'(!rd_n);
    end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic req(logic [28:0] a, logic wr, logic [1:0] sz);
    clr <= 1'h1;
    req_valid <= 1'h1;
    req_addr <= a;
    req_write <= wr;
    req_size <= sz;
    req_wdata <= $urandom;
    @(posedge mclk) clr <= 1'h0;
    do @(posedge mclk); while (req_done !== 1'h1);
    req_valid <= 1'h0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] wcr(int bst);
    return 32'(w) | 32'(bwt) << 4 | 32'(bst) << 6 | 32'(bst) << 8 | 32'(edl) << 9
      | 32'(ehl) << 13 | 32'h1 << 17;
  endfunction
  function automatic logic [31:0] pat(logic [28:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(28));
    repeat (20) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    apb(1'h0, bcb_pkg::OFS_CMN, 32'h0);
    chk("cmn reset", bcb_pkg::CMN_RST, rd);
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, bcb_pkg::OFS_BCR[i], 32'h0);
      chk("bcr reset", bcb_pkg::BCR_RST, rd);
      apb(1'h0, bcb_pkg::OFS_WCR[i], 32'h0);
      chk("wcr reset", bcb_pkg::WCR_RST, rd);
    end
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    $display("registers done");
    apb(1'h1, bcb_pkg::OFS_BCR[0], 32'h1F);
    for (int i = 0; i < 3; i++) begin
      w = 2 + $urandom % 14;
      bwt = $urandom % 4;
      apb(1'h1, bcb_pkg::OFS_WCR[0], wcr(0));
      req(29'($urandom) & 29'h3FFFFF0, 1'h0, bcb_pkg::SZ_LONG);
      chk("burst data", pat(req_addr), req_rdata);
      chk("first wait", 32'(w + 1), 32'(n_st));
      chk("burst span", 32'(w + 4 + 3 * bwt), 32'(n_rd));
    end
    $display("burst rom done");
    apb(1'h1, bcb_pkg::OFS_CMN, 32'h1);
    for (int a = 1; a < 3; a++) begin
      edl = $urandom % 16;
      ehl = $urandom % 16;
      apb(1'h1, bcb_pkg::OFS_BCR[a], 32'h16);
      apb(1'h1, bcb_pkg::OFS_WCR[a], wcr(0));
      req({1'h1, 2'(a), 26'($urandom) & 26'h1FFFFFE}, 1'h0, bcb_pkg::SZ_WORD);
      chk("card data", pat(req_addr) & 32'hFFFF, req_rdata & 32'hFFFF);
      chk("card span", 32'(edl + ehl + w + 3), 32'(n_sel));
      req(req_addr | 29'h2000000, 1'h0, bcb_pkg::SZ_WORD);
      chk("io cycle", 32'h1, 32'(n_io > 0 && n_rd == 0));
    end
    slow <= 1'h1;
    req(29'h18000000, 1'h0, bcb_pkg::SZ_WORD);
    chk("ext wait", 32'h1, 32'(n_rd > w + 1));
    slow <= 1'h0;
    req(29'h04000000, 1'h0, bcb_pkg::SZ_LONG);
    chk("req err", 32'h1, 32'(req_err));
    $display("card done");
    apb(1'h1, bcb_pkg::OFS_BCR[0], 32'h6);
    for (int b = 0; b < 2; b++) begin
      apb(1'h1, bcb_pkg::OFS_WCR[0], wcr(b));
      req(29'h100, 1'h1, bcb_pkg::SZ_WORD);
      chk("rw span", 32'(b == 0), 32'(n_rw == n_sel));
    end
    $display("byte select done");
    wrap_up();
  end
endmodule
